// *** src/rsp_ctrl.sv ***
// Command execution for relative seek, recalibrate, perpendicular mode, lock and dump.
// Assumes an Avalon-MM master on the same clock; track zero arrives from a drive pin.
// Function
// - Relative seek direction 0 steps out, 1 steps in, by the count.
// - Relative seek issues count pulses, fewer if stepping out reaches track zero, no compare, count at most 255.
// - Stepping out past track zero sets equipment check, status zero bit 4.
// - Cylinder moves one per pulse issued, up or down, modulo 256, no extended record.
// - Recalibrate uses only track zero, at most 80 pulses, error otherwise.
// - Mode-bit perpendicular choice is independent of the programmed data rate; per-drive auto mode follows it.
// - Post-ID gap 41 bytes only for 1 Mbps perpendicular, else 22.
// - Oscillator enable at 24 bytes conventional, 43 bytes in 1 Mbps perpendicular.
// - Conventional writes raise write gate at the sync field start.
// - Perpendicular write gate lead 38 bytes at 1 Mbps, 19 at 500 Kbps.
// - Both mode bits zero: per-drive bit marks that drive perpendicular.
// - Auto perpendicular drive: gap from data rate, zero precompensation.
// - Per-drive bits change only when the overwrite permit bit is 1.
// - Either mode bit set: per-drive bits ignored, global mode applies.
// - Software reset clears only the two mode bits, not per-drive bits.
// - Hardware reset clears both mode bits and all per-drive bits.
// - With lock set, software reset keeps queue and precompensation settings.
// - Hardware reset clears lock and restores queue and precompensation defaults.
// - Lock returns one result byte at once holding the new lock bit.
// - Dump eighth byte carries lock, per-drive bits and mode bits.
// - Defaults: queue off, threshold one byte, precompensation track 0, no implied seek.
//
// Our own choices: the address map and the Avalon-MM register port.
module rsp_ctrl #(
    parameter int STEP_RATE_CYC = rsp_pkg::STEP_RATE_CYC
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Avalon-MM slave
    input  wire rsp_pkg::rsp_avs_req_t avs_req,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // Drive interface
    input  wire logic                  track_zero_sense,
    output rsp_pkg::rsp_drive_t        drive,
    // Format and write timing for the selected drive
    output rsp_pkg::rsp_fmt_t          fmt
);
    import rsp_pkg::*;

    typedef struct packed {
        // Pin synchroniser
        logic              t0_meta;
        logic              t0_sync;
        // Bus side
        logic              waitreq;
        logic [31:0]       rdata;
        // Seek engine
        rsp_fsm_t          fsm;
        logic              is_recal;
        logic              dir;
        logic              abnormal;
        logic              ec;
        logic [1:0]        drv;
        logic [7:0]        remain;
        logic [3:0][7:0]   present_cylinder_number;
        logic [7:0]        st0;
        logic              seek_end;
        // Mode, lock and settings
        logic              write_gate_mode_bit;
        logic              gap_mode_bit;
        logic [3:0]        per_drive_perp_bits;
        logic              lock;
        rsp_cfg_t          cfg;
        logic [1:0]        rate;
        logic [2:0]        precomp;
        // Command results and format outputs
        logic [7:0]        result;
        logic              result_valid;
        logic              go;
        logic              abort;
        rsp_fmt_t          fmt;
    } rsp_state_t;

    rsp_state_t s_q, s_d;

    logic step_pulse;
    logic step_done;
    logic step_idle;

    rsp_stepper #(
        .STEP_RATE_CYC(STEP_RATE_CYC)
    ) u_stepper (
        .clk  (clk),
        .rst  (rst),
        .go   (s_q.go),
        .abort(s_q.abort),
        .step (step_pulse),
        .done (step_done),
        .idle (step_idle)
    );

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic        take_wr;
    logic        take_rd;
    logic [7:0]  arg;
    logic [2:0]  op;
    logic [1:0]  cmd_drv;
    logic [7:0]  dump8;
    logic [31:0] cfg_word;
    logic [31:0] rate_word;
    logic        drv_auto;
    logic        mode_1m;
    logic        mode_500k;
    logic [31:0] cfg_new;
    logic [31:0] rate_new;

    always_comb begin
        s_d       = s_q;
        s_d.go    = 1'b0;
        s_d.abort = 1'b0;

        // Track zero pin: two-stage synchroniser
        // Only the second stage is read by the seek engine
        s_d.t0_meta = track_zero_sense;
        s_d.t0_sync = s_q.t0_meta;

        // Request taken at the edge where waitrequest is low
        // One wait state lets read data be staged from settled state
        take_wr = avs_req.write && !s_q.waitreq;
        take_rd = avs_req.read && !s_q.waitreq;
        s_d.waitreq = !((avs_req.read || avs_req.write) && s_q.waitreq);

        op      = avs_req.writedata[2:0];
        cmd_drv = avs_req.writedata[CMD_DRV_POS +: 2];
        arg     = avs_req.writedata[CMD_ARG_POS +: 8];

        dump8 = {s_q.lock, 1'b0, s_q.per_drive_perp_bits, s_q.gap_mode_bit, s_q.write_gate_mode_bit};
        cfg_word  = {7'h00, s_q.lock, 7'h00, s_q.cfg.implied_seek, s_q.cfg.precomp_start_track,
                     s_q.cfg.thr, 3'h0, s_q.cfg.qdis};
        rate_word = {27'h0, s_q.precomp, s_q.rate};

        // Read data staged on the cycle before waitrequest drops
        // Busy covers the whole seek, stepping included
        unique case (avs_req.address)
            REG_STATUS: s_d.rdata = {s_q.present_cylinder_number[s_q.drv], 6'h00, s_q.result_valid, s_q.seek_end,
                                     7'h00, (s_q.fsm != RSP_IDLE), s_q.st0};
            REG_RESULT: s_d.rdata = {24'h0, s_q.result};
            REG_CONFIG: s_d.rdata = cfg_word;
            REG_PERP:   s_d.rdata = {24'h0, dump8};
            REG_RATE:   s_d.rdata = rate_word;
            REG_TIMING: s_d.rdata = {7'h00, s_q.fmt.precomp_zero, s_q.fmt.write_gate_mode_bit_lead_bytes,
                                     s_q.fmt.osc_en_bytes, s_q.fmt.post_id_gap_len};
            default:    s_d.rdata = 32'h0000_0000;
        endcase

        // Reading status ends a seek report; a new end in the same cycle wins
        // Clear only a report the returned word carried, else a late end is lost
        if (take_rd && avs_req.address == REG_STATUS && s_q.rdata[16]) begin
            s_d.seek_end = 1'b0;
        end
        if (take_rd && avs_req.address == REG_RESULT) begin
            s_d.result_valid = 1'b0;
        end

        // Seek engine
        unique case (s_q.fsm)
            RSP_IDLE: ;
            RSP_STEP: begin
                if (s_q.is_recal) begin
                    if (s_q.t0_sync) begin
                        s_d.fsm = RSP_DONE;
                    end else if (s_q.remain == 8'h00) begin
                        s_d.abnormal = 1'b1;
                        s_d.ec       = 1'b1;
                        s_d.fsm      = RSP_DONE;
                    end else begin
                        s_d.go     = 1'b1;
                        s_d.remain = s_q.remain - 8'h01;
                        s_d.fsm    = RSP_WAIT;
                    end
                end else if (s_q.remain == 8'h00) begin
                    s_d.fsm = RSP_DONE;
                end else if (!s_q.dir && s_q.t0_sync) begin
                    s_d.abnormal = 1'b1;
                    s_d.ec       = 1'b1;
                    s_d.fsm      = RSP_DONE;
                end else begin
                    s_d.go     = 1'b1;
                    s_d.remain = s_q.remain - 8'h01;
                    s_d.fsm    = RSP_WAIT;
                    if (s_q.dir) begin
                        s_d.present_cylinder_number[s_q.drv] = s_q.present_cylinder_number[s_q.drv] + 8'h01;
                    end else begin
                        s_d.present_cylinder_number[s_q.drv] = s_q.present_cylinder_number[s_q.drv] - 8'h01;
                    end
                end
            end
            RSP_WAIT: begin
                if (step_done) begin
                    s_d.fsm = RSP_STEP;
                end
            end
            RSP_DONE: begin
                // Status stays until the next seek or software reset
                s_d.st0      = {(s_q.abnormal ? IC_ABNORMAL : IC_NORMAL), 1'b1, s_q.ec, 2'b00, s_q.drv};
                s_d.seek_end = 1'b1;
                s_d.fsm      = RSP_IDLE;
            end
        endcase

        // Command writes; seek-type commands refused while one runs
        if (take_wr && avs_req.address == REG_CMD) begin
            unique case (op)
                OP_RELSEEK, OP_RECAL: begin
                    // Stepper idle also covers a pulse cut short by an abort
                    // single seek engine
                    if (s_q.fsm == RSP_IDLE && step_idle) begin
                        s_d.fsm      = RSP_STEP;
                        s_d.drv      = cmd_drv;
                        s_d.abnormal = 1'b0;
                        s_d.ec       = 1'b0;
                        s_d.is_recal = (op == OP_RECAL);
                        s_d.dir      = (op == OP_RECAL) ? 1'b0 : avs_req.writedata[CMD_DIR_POS];
                        s_d.remain   = (op == OP_RECAL) ? RECAL_MAX : arg;
                        if (op == OP_RECAL) begin
                            s_d.present_cylinder_number[cmd_drv] = 8'h00;
                        end
                    end
                end
                OP_PERP: begin
                    s_d.write_gate_mode_bit = arg[PERP_WRITE_GATE_MODE_BIT_POS];
                    s_d.gap_mode_bit        = arg[PERP_GAP_POS];
                    if (arg[PERP_OW_POS]) begin
                        s_d.per_drive_perp_bits = arg[PERP_DRV_POS +: 4];
                    end
                end
                OP_LOCK: begin
                    s_d.lock         = arg[LOCK_ARG_POS];
                    s_d.result       = 8'(arg[LOCK_ARG_POS]) << LOCK_RES_POS;
                    s_d.result_valid = 1'b1;
                end
                OP_DUMP: begin
                    s_d.result       = dump8;
                    s_d.result_valid = 1'b1;
                end
                default: ;
            endcase
        end

        // Unwritten byte lanes keep their present value
        cfg_new  = be_merge(cfg_word, avs_req.writedata, avs_req.byteenable);
        rate_new = be_merge(rate_word, avs_req.writedata, avs_req.byteenable);
        if (take_wr && avs_req.address == REG_CONFIG) begin
            s_d.cfg.qdis         = cfg_new[0];
            s_d.cfg.thr          = cfg_new[7:4];
            s_d.cfg.precomp_start_track       = cfg_new[15:8];
            s_d.cfg.implied_seek = cfg_new[16];
        end
        if (take_wr && avs_req.address == REG_RATE) begin
            s_d.rate    = rate_new[1:0];
            s_d.precomp = rate_new[4:2];
        end

        // Software reset: stands in for the output and rate register reset bits
        if (take_wr && avs_req.address == REG_SWRST && avs_req.writedata[0] && avs_req.byteenable[0]) begin
            s_d.write_gate_mode_bit = 1'b0;
            s_d.gap_mode_bit        = 1'b0;
            if (!s_q.lock) begin
                s_d.cfg = CFG_DEFAULT;
            end
            s_d.fsm          = RSP_IDLE;
            s_d.abort        = 1'b1;
            s_d.seek_end     = 1'b0;
            s_d.result_valid = 1'b0;
            s_d.st0          = 8'h00;
        end

        drv_auto = !s_q.write_gate_mode_bit && !s_q.gap_mode_bit && s_q.per_drive_perp_bits[s_q.drv];
        // Reserved write-gate-only code decodes as conventional
        // global mode ignores the rate register
        mode_1m   = s_q.write_gate_mode_bit && s_q.gap_mode_bit;
        mode_500k = !s_q.write_gate_mode_bit && s_q.gap_mode_bit;
        if (drv_auto) begin
            mode_1m   = (s_q.rate == RATE_1M);
            mode_500k = (s_q.rate != RATE_1M);
        end
        s_d.fmt.post_id_gap_len = mode_1m ? POST_ID_GAP_PERP_1M : POST_ID_GAP_CONV;
        s_d.fmt.osc_en_bytes = mode_1m ? OSC_EN_1M : OSC_EN_CONV;
        s_d.fmt.write_gate_mode_bit_lead_bytes = mode_1m ? WG_LEAD_1M : (mode_500k ? WG_LEAD_500K : WG_LEAD_CONV);
        s_d.fmt.precomp_zero = drv_auto;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // Cylinders, status and results start from zero
            s_q         <= '0;
            s_q.waitreq <= 1'b1;
            s_q.fsm     <= RSP_IDLE;
            s_q.cfg                  <= CFG_DEFAULT;
            s_q.lock                 <= 1'b0;
            s_q.per_drive_perp_bits  <= 4'h0;
            s_q.write_gate_mode_bit  <= 1'b0;
            s_q.gap_mode_bit         <= 1'b0;
            s_q.rate                 <= RATE_RESET;
            s_q.precomp              <= PRECOMP_RESET;
            s_q.fmt.post_id_gap_len         <= POST_ID_GAP_CONV;
            s_q.fmt.osc_en_bytes     <= OSC_EN_CONV;
            s_q.fmt.write_gate_mode_bit_lead_bytes <= WG_LEAD_CONV;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign drive.step      = step_pulse;
    assign drive.dir       = s_q.dir;
    assign drive.drive_sel = s_q.drv;
    assign fmt             = s_q.fmt;

endmodule // rsp_ctrl

// *** src/rsp_pkg.sv ***
// Shared constants and carrier types for the seek, perpendicular-mode and lock block.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package rsp_pkg;

    // Clock and timing
    localparam int CLK_NS         = 25;
    localparam int STEP_PULSE_NS  = 1000;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_RATE_US   = 3000;
    localparam int STEP_RATE_CYC  = (STEP_RATE_US * 1000) / CLK_NS;
    localparam int STEP_CNT_W     = 18;

    // Register byte addresses
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0c;
    localparam logic [7:0] REG_PERP   = 8'h10;
    localparam logic [7:0] REG_RATE   = 8'h14;
    localparam logic [7:0] REG_SWRST  = 8'h18;
    localparam logic [7:0] REG_TIMING = 8'h1c;

    // Command opcodes (command register bits 2:0)
    localparam logic [2:0] OP_RELSEEK = 3'h1;
    localparam logic [2:0] OP_RECAL   = 3'h2;
    localparam logic [2:0] OP_PERP    = 3'h3;
    localparam logic [2:0] OP_LOCK    = 3'h4;
    localparam logic [2:0] OP_DUMP    = 3'h5;

    // Command register fields
    localparam int CMD_DIR_POS = 3;
    localparam int CMD_DRV_POS = 4;
    localparam int CMD_ARG_POS = 8;

    // Perpendicular argument byte fields
    localparam int PERP_WRITE_GATE_MODE_BIT_POS = 0;
    localparam int PERP_GAP_POS   = 1;
    localparam int PERP_DRV_POS   = 2;
    localparam int PERP_OW_POS    = 7;
    localparam int LOCK_ARG_POS   = 7;
    localparam int LOCK_RES_POS   = 4;

    // Status register zero fields
    localparam int ST0_EC_POS = 4;
    localparam int ST0_SE_POS = 5;
    localparam logic [1:0] IC_NORMAL   = 2'h0;
    localparam logic [1:0] IC_ABNORMAL = 2'h1;

    // Gap and timing figures in bytes, recalibrate pulse limit, rate and precompensation codes
    localparam logic [7:0] POST_ID_GAP_CONV     = 8'd22;
    localparam logic [7:0] POST_ID_GAP_PERP_1M  = 8'd41;
    localparam logic [7:0] OSC_EN_CONV   = 8'd24;
    localparam logic [7:0] OSC_EN_1M     = 8'd43;
    localparam logic [7:0] WG_LEAD_CONV  = 8'd0;
    localparam logic [7:0] WG_LEAD_500K  = 8'd19;
    localparam logic [7:0] WG_LEAD_1M    = 8'd38;
    localparam logic [7:0] RECAL_MAX     = 8'd80;
    localparam logic [1:0] RATE_1M       = 2'h3;
    localparam logic [1:0] RATE_RESET    = 2'h0;
    localparam logic [2:0] PRECOMP_RESET = 3'h0;

    typedef enum logic [1:0] {
        RSP_IDLE = 2'b00,
        RSP_STEP = 2'b01,
        RSP_WAIT = 2'b11,
        RSP_DONE = 2'b10
    } rsp_fsm_t;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rsp_avs_req_t;

    typedef struct packed {
        logic       step;
        logic       dir;
        logic [1:0] drive_sel;
    } rsp_drive_t;

    typedef struct packed {
        logic [7:0] post_id_gap_len;
        logic [7:0] osc_en_bytes;
        logic [7:0] write_gate_mode_bit_lead_bytes;
        logic       precomp_zero;
    } rsp_fmt_t;

    typedef struct packed {
        logic       implied_seek;
        logic [7:0] precomp_start_track;
        logic [3:0] thr;
        logic       qdis;
    } rsp_cfg_t;

    localparam rsp_cfg_t CFG_DEFAULT = '{implied_seek: 1'b0, precomp_start_track: 8'h00, thr: 4'h0, qdis: 1'b1};

endpackage : rsp_pkg

// *** src/rsp_stepper.sv ***
// Step pulse generator: one pulse of fixed width per request, then a rate gap.
// Assumes requests arrive only while idle is high; abort returns it to idle.
module rsp_stepper #(
    parameter int STEP_RATE_CYC = rsp_pkg::STEP_RATE_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic go,
    input  wire logic abort,
    // Status
    output logic      step,
    output logic      done,
    output logic      idle
);
    import rsp_pkg::*;

    localparam logic [STEP_CNT_W-1:0] PULSE_C = STEP_CNT_W'(STEP_PULSE_CYC);
    localparam logic [STEP_CNT_W-1:0] RATE_C  = STEP_CNT_W'(STEP_RATE_CYC);

    typedef struct packed {
        logic                  busy;
        logic                  step;
        logic                  done;
        logic [STEP_CNT_W-1:0] cnt;
    } rsp_stp_t;

    rsp_stp_t s_q, s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (abort) begin
            s_d.busy = 1'b0;
            s_d.step = 1'b0;
        end else if (!s_q.busy) begin
            if (go) begin
                s_d.busy = 1'b1;
                s_d.step = 1'b1;
                s_d.cnt  = '0;
            end
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == PULSE_C - 1'b1) begin
                s_d.step = 1'b0;
            end
            // Rate never shorter than the pulse itself
            if (s_q.cnt >= RATE_C - 1'b1 && s_q.cnt >= PULSE_C) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign step = s_q.step;
    assign done = s_q.done;
    assign idle = !s_q.busy;

endmodule // rsp_stepper

// *** verif/rsp_ctrl_monitor.sv ***
// Checker on the ports of rsp_ctrl: step timing and format figures.
// Assumes one clock and synchronous active-high reset.
module rsp_ctrl_monitor #(
    parameter int STEP_RATE_CYC = 60
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire rsp_pkg::rsp_avs_req_t avs_req,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic                  track_zero_sense,
    input wire rsp_pkg::rsp_drive_t   drive,
    input wire rsp_pkg::rsp_fmt_t     fmt
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsp_pkg::*;
    logic [7:0]  hi_q;
    logic [15:0] gap_q;
    logic        prev_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        prev_q <= rst ? 1'b0 : drive.step;
        hi_q <= (rst || !drive.step) ? 8'h00 : hi_q + 8'h01;
        if (rst) gap_q <= 16'hffff;
        else if (drive.step && !prev_q) gap_q <= 16'h0001;
        else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
    end
    property p_step_width; $fell(drive.step) |-> hi_q == 8'd40; endproperty
    a_step_width: assert property (p_step_width) else $error("step pulse width wrong");
    property p_step_gap; drive.step && !prev_q |-> gap_q >= STEP_RATE_CYC + 1; endproperty
    a_step_gap: assert property (p_step_gap) else $error("step pulses too close");
    property p_dir_hold; drive.step && $past(drive.step) |-> $stable(drive.dir) && $stable(drive.drive_sel);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved in pulse");
    property p_gap_1m; fmt.post_id_gap_len == 8'd41 |-> fmt.osc_en_bytes == 8'd43 && fmt.write_gate_mode_bit_lead_bytes == 8'd38;
    endproperty
    a_gap_1m: assert property (p_gap_1m) else $error("1M timing set wrong");
    property p_gap_conv; fmt.post_id_gap_len != 8'd41 |-> fmt.post_id_gap_len == 8'd22 && fmt.osc_en_bytes == 8'd24;
    endproperty
    a_gap_conv: assert property (p_gap_conv) else $error("conventional timing wrong");
    property p_lead; fmt.write_gate_mode_bit_lead_bytes != 8'd38 |-> fmt.write_gate_mode_bit_lead_bytes inside {8'd0, 8'd19} &&
        fmt.post_id_gap_len == 8'd22; endproperty
    a_lead: assert property (p_lead) else $error("write gate lead wrong");
    property p_precomp; fmt.precomp_zero |-> fmt.write_gate_mode_bit_lead_bytes != 8'd0; endproperty
    a_precomp: assert property (p_precomp) else $error("zero precomp on conventional");
    property p_reset_fmt; $fell(rst) |-> fmt.post_id_gap_len == 8'd22 && fmt.write_gate_mode_bit_lead_bytes == 8'd0 &&
        !fmt.precomp_zero && !drive.step; endproperty
    a_reset_fmt: assert property (p_reset_fmt) else $error("reset state wrong");
    c_step: cover property (drive.step && !prev_q);
    c_1m: cover property (fmt.post_id_gap_len == 8'd41);
    c_auto: cover property (fmt.precomp_zero);
endmodule // rsp_ctrl_monitor

bind rsp_ctrl rsp_ctrl_monitor #(.STEP_RATE_CYC(STEP_RATE_CYC)) rsp_ctrl_monitor_inst (.clk(clk), .rst(rst),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .track_zero_sense(track_zero_sense), .drive(drive), .fmt(fmt));

// *** verif/rsp_drive_model.sv ***
// Floppy drive mechanism: head position moved by step pulses.
// Assumes step active high, dir 1 inward; head cannot go below track 0.
module rsp_drive_model (
    // Drive pins
    input  wire logic                clk,
    input  wire rsp_pkg::rsp_drive_t drive,
    output logic                     track_zero_sense,
    // Head position for the bench
    output int                       pos
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsp_pkg::*;
    logic step_q = 1'b0;
    initial pos = 0;
    // Mechanical end stop at track zero
    always @(posedge clk) begin
        step_q <= drive.step;
        if (drive.step && !step_q)
            pos <= drive.dir ? pos + 1 : (pos > 0 ? pos - 1 : 0);
    end
    assign track_zero_sense = (pos == 0);
endmodule // rsp_drive_model

// *** verif/tb_relseek_perpendicular_lock.sv ***
// Self-checking bench for rsp_ctrl through its Avalon-MM registers.
// Assumes the drive model on the step pins; short step rate for speed.
module tb_relseek_perpendicular_lock;
    timeunit 1ns;
    timeprecision 1ps;
    import rsp_pkg::*;
    localparam int RATE = 60;
    logic clk = 1'b0;
    logic rst = 1'b1;
    rsp_avs_req_t req = '0;
    logic [31:0] rdata;
    logic wreq, tz;
    rsp_drive_t drive;
    rsp_fmt_t fmt;
    int pos;
    int num_errors = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    rsp_ctrl #(.STEP_RATE_CYC(RATE)) rsp_ctrl_inst (.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .track_zero_sense(tz), .drive(drive), .fmt(fmt));
    rsp_drive_model rsp_drive_model_inst (.clk(clk), .drive(drive), .track_zero_sense(tz), .pos(pos));
    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        req.address <= a;
        req.read <= !wr;
        req.write <= wr;
        req.writedata <= d;
        req.byteenable <= 4'hf;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic hw_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] rs(input logic [7:0] cnt, input logic dir, input logic [1:0] drv);
        return {16'h0, cnt, 2'b00, drv, dir, OP_RELSEEK};
    endfunction
    task automatic seek(input logic [31:0] cmd, input logic [7:0] st, input logic [7:0] cyl);
        logic [31:0] q;
        q = '0;
        wr(REG_CMD, cmd);
        while (q[16] !== 1'b1) bus(1'b0, REG_STATUS, 32'h0, q);
        chk({16'h0, q[31:24], q[7:0]}, {16'h0, cyl, st});
    endtask
    task automatic t_defaults();
        rdc(REG_CONFIG, 32'h0000_0001);
        rdc(REG_PERP, 32'h0);
        rdc(REG_TIMING, 32'h0000_1816);
        rdc(8'h20, 32'h0);
    endtask
    task automatic t_seek();
        seek(rs(8'd3, 1'b1, 2'd0), 8'h20, 8'd3);
        chk(pos, 3);
        seek(rs(8'd5, 1'b0, 2'd0), 8'h70, 8'd0);
        chk(pos, 0);
        seek(rs(8'd0, 1'b1, 2'd0), 8'h20, 8'd0);
    endtask
    task automatic t_wrap();
        seek(rs(8'd255, 1'b1, 2'd0), 8'h20, 8'd255);
        seek(rs(8'd2, 1'b1, 2'd0), 8'h20, 8'd1);
        chk(pos, 257);
    endtask
    task automatic t_recal();
        for (int i = 0; i < 4; i++) begin
            seek({29'h0, OP_RECAL}, (i < 3) ? 8'h70 : 8'h20, 8'd0);
            chk(pos, (i < 3) ? 177 - 80 * i : 0);
        end
    endtask
    task automatic t_modes();
        logic [7:0] lead [4];
        lead = '{8'd0, 8'd0, 8'd19, 8'd38};
        for (int m = 0; m < 4; m++) begin
            wr(REG_CMD, {16'h0, 6'h0, 2'(m), 5'h0, OP_PERP});
            seek(rs(8'd0, 1'b1, 2'd0), 8'h20, 8'd0);
            rdc(REG_TIMING, {8'h0, lead[m], (m == 3) ? 16'h2b29 : 16'h1816});
        end
    endtask
    task automatic t_auto();
        wr(REG_CMD, {16'h0, 8'h88, 5'h0, OP_PERP});
        wr(REG_RATE, 32'h3);
        seek(rs(8'd0, 1'b1, 2'd1), 8'h21, 8'd0);
        rdc(REG_TIMING, 32'h0126_2b29);
        chk({5'h0, drive.drive_sel, fmt}, {5'h0, 2'd1, POST_ID_GAP_PERP_1M, OSC_EN_1M, WG_LEAD_1M, 1'b1});
        wr(REG_RATE, 32'h0);
        seek(rs(8'd0, 1'b1, 2'd1), 8'h21, 8'd0);
        rdc(REG_TIMING, 32'h0113_1816);
        seek(rs(8'd0, 1'b1, 2'd0), 8'h20, 8'd0);
        rdc(REG_TIMING, 32'h0000_1816);
        wr(REG_CMD, {16'h0, 8'h03, 5'h0, OP_PERP});
        rdc(REG_PERP, 32'h0b);
        seek(rs(8'd0, 1'b1, 2'd1), 8'h21, 8'd0);
        rdc(REG_TIMING, 32'h0026_2b29);
        wr(REG_SWRST, 32'h1);
        rdc(REG_PERP, 32'h08);
    endtask
    task automatic t_lock();
        wr(REG_CONFIG, 32'h0000_0750);
        wr(REG_CMD, {16'h0, 8'h80, 5'h0, OP_LOCK});
        rdc(REG_RESULT, 32'h10);
        wr(REG_SWRST, 32'h1);
        rdc(REG_CONFIG, 32'h0100_0750);
        rdc(REG_PERP, 32'h88);
        hw_reset();
        rdc(REG_CONFIG, 32'h0000_0001);
        rdc(REG_PERP, 32'h0);
        wr(REG_CONFIG, 32'h0000_0750);
        wr(REG_SWRST, 32'h1);
        rdc(REG_CONFIG, 32'h0000_0001);
    endtask
    initial begin
        hw_reset();
        t_defaults();
        t_seek();
        t_wrap();
        t_recal();
        t_modes();
        t_auto();
        t_lock();
        tally_and_finish();
    end
    // Run needs about 33k cycles; over twice that before giving up
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_relseek_perpendicular_lock
